/* design/sbfs_supervisor.sv */
// supply, brown-out and protection-window supervisor with apb registers
`timescale 1ns/1ps
`default_nettype none
`include "sbfs_regs.svh"
// Notes on behaviour
// R1: startup source turns off once supply reaches start threshold.
// R2: bulk_ok rise, recovery end, remote event, thermal end re-enable source.
// R3: weak aux bias gives self-supply cycling, no drive while supply charges.
// R4: off-mode and fault cycle the supply and give no drive at all.
// R5: hysteresis sink on only while bulk_ok is low.
// R6: bulk sense pin discharged while supply rises from reset to start.
// R7: at start threshold sink turns on and discharge releases together.
// R8: resonant stage switches only while bulk voltage is adequate.
// R9: brown-out comparator filtered for bulk_filter_time before bulk_ok.
// R10: preconverter bias removed in light load, off-mode and fault.
// R11: operation only while protection pin sits inside no-fault window.
// R12: leaving window longer than its filter time stops switching.
// R13: trip latches or starts auto-recovery per option, recording the cause.
// R14: overtemperature comparator ignored during startup blanking time.
// R15: boosted bias current selected while filter capacitor charges.
// R16: protection enabled on start, bulk_ok, restart, skip exit, remote on.
// R17: protection bias off on low supply, bulk_ok fall, fault, skip, off.
// R18: latched protection keeps supply cycling with no driver pulses.
// R19: protection latch clears only when supply falls below reset level.
// R20: filters and blanking restart on input change, act at full count.
module sbfs_supervisor #(
    parameter int unsigned BLANK_CYC = `SBFS_OTP_BLANK_CYC,
    parameter int unsigned AUTOREC_CYC = `SBFS_AUTOREC_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_above_start,
    input wire logic supply_above_stop,
    input wire logic supply_above_reset,
    input wire logic bulk_cmp,
    input wire logic overvoltage_cmp,
    input wire logic overtemp_cmp,
    input wire logic skip_active,
    input wire logic remote_off,
    input wire logic remote_on,
    input wire logic thermal_shutdown,
    output logic startup_source_en,
    output logic hysteresis_sink_en,
    output logic bulk_discharge_en,
    output logic driver_enable,
    output logic preconverter_control_output,
    output logic thermistor_bias_en,
    output logic boosted_bias_sel
);
    import sbfs_pkg::*;

    localparam int NSYNC = 7;
    sbfs_main_s q, d;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn_in;
    logic vcc_on, vcc_ok, vcc_live, skip_s, roff_s, ron_s, tsd_s;
    logic bulk_ok, ovp_f, otp_f, blank_run, ar_done, otp_seen, trip;
    logic apb_acc, wr_en;
    logic [31:0] rd_val;

    assign raw_in = {thermal_shutdown, remote_on, remote_off, skip_active,
                     supply_above_reset, supply_above_stop, supply_above_start};

    // two-flop synchronisers, each followed by a one-cycle output flop
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            sbfs_filter #(.LEN(1)) u_sync (
                .pclk(pclk),
                .presetn(presetn),
                .raw(raw_in[gi]),
                .filt(syn_in[gi])
            );
        end
    endgenerate

    assign vcc_on = syn_in[0];
    assign vcc_ok = syn_in[1];
    assign vcc_live = syn_in[2];
    assign skip_s = syn_in[3];
    assign roff_s = syn_in[4];
    assign ron_s = syn_in[5];
    assign tsd_s = syn_in[6];

    // R9: bulk noise filter
    sbfs_filter #(.LEN(`SBFS_BULK_FILT_CYC)) u_bulk (
        .pclk(pclk),
        .presetn(presetn),
        .raw(bulk_cmp),
        .filt(bulk_ok)
    );

    // R12: separate window filters
    sbfs_filter #(.LEN(`SBFS_OVP_FILT_CYC)) u_ovp (
        .pclk(pclk),
        .presetn(presetn),
        .raw(overvoltage_cmp),
        .filt(ovp_f)
    );

    sbfs_filter #(.LEN(`SBFS_OTP_FILT_CYC)) u_otp (
        .pclk(pclk),
        .presetn(presetn),
        .raw(overtemp_cmp),
        .filt(otp_f)
    );

    // R14: startup blanking timer
    sbfs_timer u_blank (
        .pclk(pclk),
        .presetn(presetn),
        .start(q.blank_start),
        .len(32'(BLANK_CYC)),
        .running(blank_run),
        .done()
    );

    // R13: auto-recovery timer
    sbfs_timer u_autorec (
        .pclk(pclk),
        .presetn(presetn),
        .start(q.ar_start),
        .len(32'(AUTOREC_CYC)),
        .running(),
        .done(ar_done)
    );

    // R14: overtemperature masked while blanking
    assign otp_seen = otp_f && !blank_run;
    // R11: window check
    assign trip = q.prot_en && (ovp_f || otp_seen);

    assign apb_acc = psel && penable && !q.pready;
    assign wr_en = psel && penable && q.pready && pwrite;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `SBFS_ADDR_CTRL: rd_val[1:0] = q.ctrl;
            `SBFS_ADDR_FAULT: rd_val[1:0] = q.fault;
            `SBFS_ADDR_STATUS: begin
                rd_val[`SBFS_ST_STATE_LSB +: 3] = q.st;
                rd_val[`SBFS_ST_BULK_OK] = bulk_ok;
                rd_val[`SBFS_ST_PROT_EN] = q.prot_en;
                rd_val[`SBFS_ST_SOURCE] = q.src_en;
                rd_val[`SBFS_ST_DRIVE] = q.drv_en;
                rd_val[`SBFS_ST_PRECONV] = q.pfc_en;
                rd_val[`SBFS_ST_BLANK] = blank_run;
            end
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        d = q;
        d.blank_start = 1'b0;
        d.ar_start = 1'b0;
        d.bulk_prev = bulk_ok;
        d.tsd_prev = tsd_s;
        d.skip_prev = skip_s;

        // apb: one wait cycle, then answer
        d.pready = apb_acc;
        if (apb_acc) begin
            d.prdata = rd_val;
            d.pslverr = (paddr != `SBFS_ADDR_CTRL) && (paddr != `SBFS_ADDR_STATUS) &&
                        (paddr != `SBFS_ADDR_FAULT);
        end else begin
            d.prdata = 32'h0000_0000;
            d.pslverr = 1'b0;
        end
        if (wr_en && paddr == `SBFS_ADDR_CTRL) begin
            d.ctrl = pwdata[1:0];
        end
        if (wr_en && paddr == `SBFS_ADDR_FAULT) begin
            d.fault = q.fault & ~pwdata[1:0];
        end

        if (!vcc_live) begin
            // R19: only a full supply collapse leaves the latch
            d.st = S_POR;
            d.charge = 1'b1;
            d.prot_en = 1'b0;
        end else begin
            unique case (q.st)
                S_POR: begin
                    d.charge = 1'b1;
                    // R16: first rise to start
                    if (vcc_on) begin
                        d.st = S_RUN;
                        d.charge = 1'b0;
                        d.prot_en = 1'b1;
                        d.blank_start = 1'b1;
                    end
                end
                S_RUN: begin
                    // R1: aux winding takes over
                    if (vcc_on) begin
                        d.charge = 1'b0;
                    end
                    if (!vcc_ok) begin
                        // R3: fall into self-supply cycling
                        d.st = S_SELF;
                        d.charge = 1'b1;
                        // R17: supply below stop
                        d.prot_en = 1'b0;
                    end else if (roff_s) begin
                        // R17: off-mode entry
                        d.st = S_OFF;
                        d.prot_en = 1'b0;
                    end else if (trip) begin
                        // R13: record cause, pick latch or timer
                        d.prot_en = 1'b0;
                        if (ovp_f) begin
                            d.fault[`SBFS_FAULT_OVP] = 1'b1;
                        end
                        if (otp_seen) begin
                            d.fault[`SBFS_FAULT_OTP] = 1'b1;
                        end
                        if ((ovp_f && q.ctrl[`SBFS_CTRL_OVP_LATCH]) ||
                            (otp_seen && q.ctrl[`SBFS_CTRL_OTP_LATCH])) begin
                            d.st = S_LATCH;
                        end else begin
                            d.st = S_AUTOREC;
                            d.ar_start = 1'b1;
                        end
                    end else begin
                        // R17: skip entry and bulk_ok fall
                        if ((skip_s && !q.skip_prev) || (!bulk_ok && q.bulk_prev)) begin
                            d.prot_en = 1'b0;
                        end
                        // R16: skip exit and bulk_ok received
                        if ((!skip_s && q.skip_prev) || (bulk_ok && !q.bulk_prev)) begin
                            d.prot_en = 1'b1;
                            d.blank_start = 1'b1;
                        end
                    end
                end
                S_SELF: begin
                    // R3: back to run at start threshold
                    if (vcc_on) begin
                        d.st = S_RUN;
                        d.charge = 1'b0;
                        d.prot_en = 1'b1;
                        d.blank_start = 1'b1;
                    end
                end
                S_OFF: begin
                    // R2: remote event restarts charging
                    if (ron_s) begin
                        d.st = S_SELF;
                        d.charge = 1'b1;
                    end
                end
                S_AUTOREC: begin
                    // R2: recovery timer end restarts charging
                    if (ar_done) begin
                        d.st = S_SELF;
                        d.charge = 1'b1;
                    end
                end
                S_LATCH: begin
                    d.st = S_LATCH;
                end
                default: d.st = S_POR;
            endcase

            // R4: cycling between thresholds while parked
            // R18: latch keeps cycling
            if (q.st == S_OFF || q.st == S_AUTOREC || q.st == S_LATCH) begin
                if (!vcc_ok) begin
                    d.charge = 1'b1;
                end else if (vcc_on) begin
                    d.charge = 1'b0;
                end
            end
            // R2: bulk_ok rise and thermal end
            if ((bulk_ok && !q.bulk_prev) || (!tsd_s && q.tsd_prev)) begin
                d.charge = 1'b1;
            end
        end

        d.src_en = d.charge && !tsd_s;
        // R5: sink on while bulk low
        // R7: sink and discharge switch flip at start
        d.sink_en = !bulk_ok && (d.st != S_POR);
        // R6: discharge during startup ramp
        d.dis_en = (d.st == S_POR);
        // R8: drive only with bulk_ok and in window
        // R4: no pulses while parked or charging
        d.drv_en = (d.st == S_RUN) && bulk_ok && !skip_s && !ovp_f && !otp_seen && !d.charge && d.prot_en;
        // R10: preconverter bias off at light load, off, fault
        d.pfc_en = (d.st == S_RUN) && !skip_s;
        // R15: boost while filter cap charges
        d.boost = d.prot_en && (blank_run || d.blank_start);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
            q.st <= S_POR;
            q.charge <= 1'b1;
            q.src_en <= 1'b1;
            q.dis_en <= 1'b1;
            q.ctrl <= `SBFS_CTRL_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign pslverr = q.pslverr;
    assign startup_source_en = q.src_en;
    assign hysteresis_sink_en = q.sink_en;
    assign bulk_discharge_en = q.dis_en;
    assign driver_enable = q.drv_en;
    assign preconverter_control_output = q.pfc_en;
    assign thermistor_bias_en = q.prot_en;
    assign boosted_bias_sel = q.boost;
endmodule // sbfs_supervisor
`default_nettype wire

/* design/sbfs_regs.svh */
// register map, reset values and timing counts of the supply supervisor
`ifndef SBFS_REGS_SVH
`define SBFS_REGS_SVH
`define SBFS_CLK_MHZ 25
`define SBFS_ADDR_CTRL 12'h000
`define SBFS_ADDR_STATUS 12'h004
`define SBFS_ADDR_FAULT 12'h008
`define SBFS_CTRL_OVP_LATCH 0
`define SBFS_CTRL_OTP_LATCH 1
`define SBFS_CTRL_RST 2'h3
`define SBFS_FAULT_OVP 0
`define SBFS_FAULT_OTP 1
`define SBFS_ST_STATE_LSB 0
`define SBFS_ST_BULK_OK 4
`define SBFS_ST_PROT_EN 5
`define SBFS_ST_SOURCE 6
`define SBFS_ST_DRIVE 7
`define SBFS_ST_PRECONV 8
`define SBFS_ST_BLANK 9
`define SBFS_BULK_FILT_US 20
`define SBFS_OVP_FILT_US 40
`define SBFS_OTP_FILT_US 40
`define SBFS_OTP_BLANK_US 8000
`define SBFS_AUTOREC_US 1000000
`define SBFS_BULK_FILT_CYC (`SBFS_BULK_FILT_US * `SBFS_CLK_MHZ)
`define SBFS_OVP_FILT_CYC (`SBFS_OVP_FILT_US * `SBFS_CLK_MHZ)
`define SBFS_OTP_FILT_CYC (`SBFS_OTP_FILT_US * `SBFS_CLK_MHZ)
`define SBFS_OTP_BLANK_CYC (`SBFS_OTP_BLANK_US * `SBFS_CLK_MHZ)
`define SBFS_AUTOREC_CYC (`SBFS_AUTOREC_US * `SBFS_CLK_MHZ)
`endif

/* design/sbfs_pkg.sv */
// types of the supply supervisor
package sbfs_pkg;
    typedef enum logic [2:0] {S_POR, S_RUN, S_SELF, S_OFF, S_AUTOREC, S_LATCH} sbfs_state_e;

    typedef struct packed {
        logic s1;
        logic s2;
        logic out;
        logic [15:0] cnt;
    } sbfs_filt_s;

    typedef struct packed {
        logic [31:0] cnt;
        logic done;
    } sbfs_tmr_s;

    typedef struct packed {
        sbfs_state_e st;
        logic charge;
        logic bulk_prev;
        logic tsd_prev;
        logic skip_prev;
        logic prot_en;
        logic [1:0] ctrl;
        logic [1:0] fault;
        logic src_en;
        logic sink_en;
        logic dis_en;
        logic drv_en;
        logic pfc_en;
        logic boost;
        logic blank_start;
        logic ar_start;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } sbfs_main_s;
endpackage

/* design/sbfs_filter.sv */
// two-flop synchroniser followed by a restartable glitch filter
`timescale 1ns/1ps
`default_nettype none
module sbfs_filter #(
    parameter int unsigned LEN = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic raw,
    output logic filt
);
    import sbfs_pkg::*;
    localparam logic [15:0] LIM = 16'(LEN - 1);
    sbfs_filt_s q, d;

    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        // R20: restart on change
        if (q.s2 == q.out) begin
            d.cnt = 16'h0000;
        end else if (q.cnt >= LIM) begin
            d.out = q.s2;
            d.cnt = 16'h0000;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign filt = q.out;
endmodule // sbfs_filter
`default_nettype wire

/* design/sbfs_timer.sv */
// one-shot down counter with running level and end pulse
`timescale 1ns/1ps
`default_nettype none
module sbfs_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [31:0] len,
    output logic running,
    output logic done
);
    import sbfs_pkg::*;
    sbfs_tmr_s q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (start) begin
            d.cnt = len;
        end else if (q.cnt != 32'h0000_0000) begin
            d.cnt = q.cnt - 32'h0000_0001;
            d.done = (q.cnt == 32'h0000_0001);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign running = (q.cnt != 32'h0000_0000);
    assign done = q.done;
endmodule // sbfs_timer
`default_nettype wire

/* verification/sbfs_supply_model.sv */
// behavioural supply rail and bulk comparator beside the supervisor
`timescale 1ns/1ps
`default_nettype none
module sbfs_supply_model (
    input wire logic pclk,
    input wire logic mains_on,
    input wire logic aux_ok,
    input wire logic bulk_high,
    input wire logic startup_source_en,
    input wire logic bulk_discharge_en,
    output logic supply_above_start,
    output logic supply_above_stop,
    output logic supply_above_reset,
    output logic bulk_cmp
);
    int vcc = 0;
    // rail charges from the source, holds on aux bias, else sags
    always @(posedge pclk) begin
        if (mains_on && startup_source_en && vcc < 70) begin
            vcc <= vcc + 1;
        end else if ((!mains_on || !aux_ok || vcc < 40) && vcc > 0) begin
            vcc <= vcc - 1;
        end
    end
    assign supply_above_start = (vcc >= 60);
    assign supply_above_stop = (vcc >= 40);
    assign supply_above_reset = (vcc >= 10);
    // discharge switch holds the sense pin under the comparator level
    assign bulk_cmp = bulk_high && !bulk_discharge_en;
endmodule // sbfs_supply_model
`default_nettype wire

/* verification/sbfs_supervisor_asserts.sv */
// sequencing checks of the supply supervisor
`timescale 1ns/1ps
`default_nettype none
`include "sbfs_regs.svh"
module sbfs_supervisor_asserts #(
    parameter int unsigned BLANK_CYC = 20,
    parameter int unsigned AUTOREC_CYC = 50
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic supply_above_start,
    input wire logic supply_above_stop,
    input wire logic bulk_cmp,
    input wire logic overvoltage_cmp,
    input wire logic skip_active,
    input wire logic startup_source_en,
    input wire logic hysteresis_sink_en,
    input wire logic bulk_discharge_en,
    input wire logic driver_enable,
    input wire logic preconverter_control_output,
    input wire logic thermistor_bias_en,
    input wire logic boosted_bias_sel
);
    localparam int BULK_LEN = `SBFS_BULK_FILT_CYC;
    localparam int OVP_LEN = `SBFS_OVP_FILT_CYC;
    logic [15:0] bhi_q, blo_q, ovp_q, boost_q;
    function automatic logic [15:0] inc(input logic [15:0] c);
        return (c == 16'hffff) ? c : c + 16'h1;
    endfunction
    // run lengths of the watched levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bhi_q <= '0;
            blo_q <= '0;
            ovp_q <= '0;
            boost_q <= '0;
        end else begin
            bhi_q <= bulk_cmp ? inc(bhi_q) : '0;
            blo_q <= bulk_cmp ? '0 : inc(blo_q);
            ovp_q <= overvoltage_cmp ? inc(ovp_q) : '0;
            boost_q <= boosted_bias_sel ? inc(boost_q) : '0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence start_seen;
        $rose(supply_above_start) ##1 supply_above_start [*8];
    endsequence
    sequence skip_held;
        skip_active [*8];
    endsequence
    src_off_a: assert property (start_seen |-> !startup_source_en) else $error("source on above start");
    low_nodrive_a: assert property (!supply_above_stop [*8] |-> !driver_enable) else $error("drive on low rail");
    disch_hold_a: assert property (bulk_discharge_en && !supply_above_start |=> bulk_discharge_en)
        else $error("discharge left early");
    sink_swap_a: assert property ($fell(bulk_discharge_en) && !bulk_cmp |-> hysteresis_sink_en)
        else $error("sink not on at release");
    bulk_stop_a: assert property (blo_q >= BULK_LEN + 8 |-> !driver_enable) else $error("drive on low bulk");
    bulk_wait_a: assert property ($rose(driver_enable) |-> bhi_q >= BULK_LEN) else $error("drive before filter");
    skip_pfc_a: assert property (skip_held |-> !preconverter_control_output) else $error("preconv on in skip");
    ovp_stop_a: assert property (ovp_q >= OVP_LEN + 8 |-> !driver_enable) else $error("drive on overvoltage");
    boost_len_a: assert property (boost_q <= BLANK_CYC + 8) else $error("boost held too long");
    skip_bias_a: assert property (skip_held |-> !thermistor_bias_en) else $error("bias on in skip");
    apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("no apb answer");
endmodule // sbfs_supervisor_asserts
bind sbfs_supervisor sbfs_supervisor_asserts #(.BLANK_CYC(BLANK_CYC), .AUTOREC_CYC(AUTOREC_CYC)) u_chk (
    .pclk, .presetn, .psel, .penable, .pready, .supply_above_start, .supply_above_stop,
    .bulk_cmp, .overvoltage_cmp, .skip_active, .startup_source_en, .hysteresis_sink_en,
    .bulk_discharge_en, .driver_enable, .preconverter_control_output, .thermistor_bias_en,
    .boosted_bias_sel);
`default_nettype wire

/* verification/supply_brownout_fault_supervisor_test.sv */
// self-checking bench of the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module supply_brownout_fault_supervisor_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic supply_above_start, supply_above_stop, supply_above_reset, bulk_cmp;
    logic overvoltage_cmp, overtemp_cmp, skip_active, remote_off, remote_on, thermal_shutdown;
    logic startup_source_en, hysteresis_sink_en, bulk_discharge_en, driver_enable;
    logic preconverter_control_output, thermistor_bias_en, boosted_bias_sel;
    logic mains_on, aux_ok, bulk_high;
    int n_fail, n_compared;
    sbfs_supervisor #(.BLANK_CYC(20), .AUTOREC_CYC(50)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .supply_above_start, .supply_above_stop, .supply_above_reset, .bulk_cmp, .overvoltage_cmp,
        .overtemp_cmp, .skip_active, .remote_off, .remote_on, .thermal_shutdown, .startup_source_en,
        .hysteresis_sink_en, .bulk_discharge_en, .driver_enable, .preconverter_control_output,
        .thermistor_bias_en, .boosted_bias_sel);
    sbfs_supply_model u_sup (
        .pclk, .mains_on, .aux_ok, .bulk_high, .startup_source_en, .bulk_discharge_en,
        .supply_above_start, .supply_above_stop, .supply_above_reset, .bulk_cmp);
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rd & m, e);
    endtask
    task t_regs;
        rdc(12'h000, 32'h3, 32'h3); // latch option
        apb(1, 12'h00c, 32'h3);
        chk(er, 1'b1); // unmapped write
        apb(0, 12'h00c, 32'h0);
        chk(er, 1'b1); // unmapped read
        chk(rd, 32'h0); // unmapped data
    endtask
    task t_start;
        repeat (200) if (startup_source_en !== 1'b0) @(posedge pclk);
        chk(startup_source_en, 1'b0); // source off
        chk(bulk_discharge_en, 1'b0); // release
        chk(hysteresis_sink_en, 1'b1); // sink on
        chk(thermistor_bias_en, 1'b1); // first start
        chk(boosted_bias_sel, 1'b1); // boost
        chk(driver_enable, 1'b0); // no bulk
        repeat (40) @(posedge pclk);
        chk(boosted_bias_sel, 1'b0); // normal bias
        rdc(12'h004, 32'h7, 32'h1);
        thermal_shutdown <= 1;
        repeat (10) @(posedge pclk);
        chk(startup_source_en, 1'b0);
        thermal_shutdown <= 0;
        @(posedge pclk);
        repeat (10) if (startup_source_en !== 1'b1) @(posedge pclk);
        chk(startup_source_en, 1'b1); // thermal end
        repeat (30) @(posedge pclk);
    endtask
    task t_bulk;
        bulk_high <= 1;
        repeat (300) @(posedge pclk);
        chk(driver_enable, 1'b0); // filtering
        bulk_high <= 0;
        @(posedge pclk);
        bulk_high <= 1;
        repeat (480) @(posedge pclk);
        chk(driver_enable, 1'b0); // restart
        repeat (100) if (driver_enable !== 1'b1) @(posedge pclk);
        chk(driver_enable, 1'b1); // bulk ok
        chk(hysteresis_sink_en, 1'b0); // sink off
        chk(preconverter_control_output, 1'b1); // biased
    endtask
    task t_modes;
        skip_active <= 1;
        repeat (12) @(posedge pclk);
        chk(preconverter_control_output, 1'b0); // skip
        skip_active <= 0;
        @(posedge pclk);
        repeat (12) if (thermistor_bias_en !== 1'b1) @(posedge pclk);
        chk(thermistor_bias_en, 1'b1); // skip exit
        remote_off <= 1;
        repeat (12) @(posedge pclk);
        chk(driver_enable, 1'b0); // off-mode
        chk(thermistor_bias_en, 1'b0); // off-mode
        chk(preconverter_control_output, 1'b0); // off-mode
        remote_off <= 0;
        remote_on <= 1;
        @(posedge pclk);
        repeat (300) if (driver_enable !== 1'b1) @(posedge pclk);
        remote_on <= 0;
        chk(driver_enable, 1'b1); // resume
        chk(thermistor_bias_en, 1'b1); // remote on
    endtask
    task trip;
        overvoltage_cmp <= 1;
        repeat (900) @(posedge pclk);
        chk(driver_enable, 1'b1); // filter time
        repeat (300) if (driver_enable !== 1'b0) @(posedge pclk);
        chk(driver_enable, 1'b0); // stop
        chk(thermistor_bias_en, 1'b0); // fault
        overvoltage_cmp <= 0;
    endtask
    task t_latch;
        trip;
        rdc(12'h008, 32'h3, 32'h1); // cause
        rdc(12'h004, 32'h7, 32'h5); // latched
        apb(1, 12'h008, 32'h1);
        rdc(12'h008, 32'h3, 32'h0);
        aux_ok <= 0;
        repeat (300) @(posedge pclk);
        chk(driver_enable, 1'b0); // no pulses
        rdc(12'h004, 32'h7, 32'h5); // held
        mains_on <= 0;
        repeat (100) @(posedge pclk);
        rdc(12'h004, 32'h7, 32'h0); // cleared
        repeat (700) @(posedge pclk);
        mains_on <= 1;
        aux_ok <= 1;
        @(posedge pclk);
        repeat (2000) if (driver_enable !== 1'b1) @(posedge pclk);
        chk(driver_enable, 1'b1); // restart
    endtask
    task t_auto;
        apb(1, 12'h000, 32'h0);
        rdc(12'h000, 32'h3, 32'h0); // option
        trip;
        rdc(12'h004, 32'h7, 32'h4); // recovery
        rdc(12'h008, 32'h3, 32'h1); // cause
        repeat (2000) if (driver_enable !== 1'b1) @(posedge pclk);
        chk(driver_enable, 1'b1); // restart
    endtask
    task finish_test;
        $display("mismatches %0d compares %0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        pclk = 0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        n_fail++;
        finish_test;
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {overvoltage_cmp, overtemp_cmp, skip_active, remote_off, remote_on, thermal_shutdown} = '0;
        {presetn, bulk_high, n_fail, n_compared} = '0;
        mains_on = 1;
        aux_ok = 1;
        repeat (20) @(posedge pclk);
        chk(startup_source_en, 1'b1); // charging
        chk(bulk_discharge_en, 1'b1); // pulled low
        chk(driver_enable, 1'b0);
        presetn <= 1;
        @(posedge pclk);
        t_regs;
        t_start;
        t_bulk;
        t_modes;
        t_latch;
        t_auto;
        finish_test;
    end
endmodule // supply_brownout_fault_supervisor_test
`default_nettype wire
